/* File: pkg/cloc_defines.svh */
`ifndef CLOC_DEFINES_SVH
`define CLOC_DEFINES_SVH

// register indices; byte address is four times the index
`define CLOC_IDX_TRIM       8'h74
`define CLOC_IDX_LOAD_ADJ   8'h77
`define CLOC_IDX_SRC_SEL    8'h7c
`define CLOC_IDX_DIV_CTRL   8'h7d
`define CLOC_IDX_OUT_EN     8'h7e
`define CLOC_IDX_SOFT_RST   8'h7f
`define CLOC_IDX_KEY        8'ha0

// security key value (arbitrary)
`define CLOC_KEY_VALUE      16'h5a3c

// field reset values
`define CLOC_RST_LOAD_ADJ   4'h0
`define CLOC_RST_SEL2       2'h0
`define CLOC_RST_SEL3_LOCK  2'h2
`define CLOC_RST_SEL3_FREE  2'h0
`define CLOC_RST_B_DIV      1'h0
`define CLOC_RST_C_DIV      1'h1
`define CLOC_RST_MCLK_DIV   2'h1
`define CLOC_RST_DIV3       1'h0
`define CLOC_FORCE_DIV      1'h1
`define CLOC_FREE_DIV       1'h0
`define CLOC_SEL5_FLL       1'h1
`define CLOC_SEL5_OSC       1'h0
`define CLOC_RST_OE         5'h1f

// strap settle time in cycles after reset release
`define CLOC_INIT_CYCLES    2'h3

`endif

/* File: pkg/cloc_pkg.sv */
`default_nettype none
package cloc_pkg;

	typedef struct packed {
		logic [1:0] second_output_source;
		logic [1:0] third_output_source;
		logic       fifth_output_source;
		logic       synth_b_output_divider;
		logic       synth_c_output_divider;
		logic [1:0] master_clock_divider;
		logic       third_output_divide;
		logic       second_output_divide;
		logic       fifth_output_divide;
		logic       second_output_enable;
		logic       third_output_enable;
		logic       fifth_output_enable;
		logic [3:0] output_crystal_load_adjust;
		logic [3:0] input_crystal_load_adjust;
	} cloc_cfg_t;

	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [11:0] paddr;
		logic [31:0] pwdata;
	} cloc_apb_req_t;

	typedef struct packed {
		logic        pready;
		logic [31:0] prdata;
		logic        pslverr;
	} cloc_apb_rsp_t;

endpackage

`default_nettype wire

/* File: rtl/cloc_top.sv */
// Added by the designer: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "cloc_defines.svh"

// Summary of operation
// - five-bit output crystal trim is filled by hardware, read-only, 8pF plus 0.5pF steps
// - trim read-back is reachable only after the security key is written
// - output crystal load adjust, bits 7:4, signed, 0.5pF steps
// - input crystal load adjust, bits 3:0, signed, defaults to zero
// - second output source: synth_b, gpio_two, oscillator, reserved
// - third output source forced to frequency locked loop while override is low
// - override high: third source defaults to synth_c and is writable
// - fifth source: oscillator at 0, loop at 1; follows strap when override low
// - override low and strap low: fifth source forced to 1, writes rejected
// - strap high or override high: fifth source defaults to 0, writable
// - synth_b output divider: 0 halves, 1 quarters; default 0
// - synth_c output divider: 0 halves, 1 quarters; default 1
// - master clock divider: 1, 2, 4, reserved; default divide by two
// - third output divide: 0 passes, 1 halves; default 0
// - second output divide forced to 1 when override low, else default 0 writable
// - fifth output divide forced to 1 when override low, else default 0 writable
// - output enables of second, third, fifth pins default on; 0 tri-states
// - any write to soft reset restores all clocking registers to defaults

module cloc_top
	import cloc_pkg::*;
(
	// clock and reset
	input  wire logic        clk,
	input  wire logic        reset,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic             pready,
	output logic      [31:0] prdata,
	output logic             pslverr,
	// straps and trim source
	input  wire logic        clock_lock_override,
	input  wire logic        osc_select_pin,
	input  wire logic [4:0]  trim_code,
	// configuration to the clock tree
	output cloc_cfg_t        cfg
);

	// ------------------------------------------------------------
	// strap synchronisers
	// ------------------------------------------------------------
	logic [1:0] ovd_sync;
	logic [1:0] osc_sync;
	logic       ovd;
	logic       strap;

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			ovd_sync <= 2'h0;
			osc_sync <= 2'h0;
		end else begin
			ovd_sync <= {ovd_sync[0], clock_lock_override};
			osc_sync <= {osc_sync[0], osc_select_pin};
		end
	end

	assign ovd   = ovd_sync[1];
	assign strap = osc_sync[1];

	// ------------------------------------------------------------
	// register state
	// ------------------------------------------------------------
	logic [4:0] trim;
	logic       unlocked;
	logic [1:0] init_cnt;
	logic [3:0] out_adj;
	logic [3:0] in_adj;
	logic [1:0] sel2;
	logic [1:0] sel3;
	logic       sel5;
	logic       b_div;
	logic       c_div;
	logic [1:0] mclk_div;
	logic       div3;
	logic       div2;
	logic       div5;
	logic [4:0] oe;

	logic [4:0] next_trim;
	logic       next_unlocked;
	logic [1:0] next_init_cnt;
	logic [3:0] next_out_adj;
	logic [3:0] next_in_adj;
	logic [1:0] next_sel2;
	logic [1:0] next_sel3;
	logic       next_sel5;
	logic       next_b_div;
	logic       next_c_div;
	logic [1:0] next_mclk_div;
	logic       next_div3;
	logic       next_div2;
	logic       next_div5;
	logic [4:0] next_oe;

	// locks and effective field values
	logic       lock_main;
	logic       lock_sel5;
	logic [1:0] eff_sel3;
	logic       eff_sel5;
	logic       eff_div2;
	logic       eff_div5;

	assign lock_main = ~ovd;
	assign lock_sel5 = ~ovd & ~strap;
	assign eff_sel3  = lock_main ? `CLOC_RST_SEL3_LOCK : sel3;
	assign eff_sel5  = lock_sel5 ? `CLOC_SEL5_FLL : sel5;
	assign eff_div2  = lock_main ? `CLOC_FORCE_DIV : div2;
	assign eff_div5  = lock_main ? `CLOC_FORCE_DIV : div5;

	// ------------------------------------------------------------
	// bus decode
	// ------------------------------------------------------------
	logic        setup;
	logic        wr_en;
	logic [7:0]  idx;
	logic        aligned;
	logic        hit;
	logic [15:0] wd;

	assign setup   = psel & ~penable;
	assign wr_en   = psel & penable & pready & pwrite & ~pslverr;
	assign idx     = paddr[9:2];
	assign aligned = (paddr[1:0] == 2'h0) & (paddr[11:10] == 2'h0);
	assign wd      = pwdata[15:0];

	always_comb begin
		case (idx)
			`CLOC_IDX_TRIM, `CLOC_IDX_LOAD_ADJ, `CLOC_IDX_SRC_SEL, `CLOC_IDX_DIV_CTRL,
			`CLOC_IDX_OUT_EN, `CLOC_IDX_SOFT_RST, `CLOC_IDX_KEY: hit = aligned;
			default: hit = 1'b0;
		endcase
	end

	// ------------------------------------------------------------
	// next state of the registers
	// ------------------------------------------------------------
	always_comb begin
		next_trim     = trim_code;
		next_unlocked = unlocked;
		next_init_cnt = init_cnt;
		next_out_adj  = out_adj;
		next_in_adj   = in_adj;
		next_sel2     = sel2;
		next_sel3     = sel3;
		next_sel5     = sel5;
		next_b_div    = b_div;
		next_c_div    = c_div;
		next_mclk_div = mclk_div;
		next_div3     = div3;
		next_div2     = div2;
		next_div5     = div5;
		next_oe       = oe;
		if (init_cnt != 2'h0) begin
			next_init_cnt = init_cnt - 2'h1;
		end
		if (wr_en) begin
			case (idx)
				`CLOC_IDX_KEY: begin
					next_unlocked = (wd == `CLOC_KEY_VALUE);
				end
				`CLOC_IDX_LOAD_ADJ: begin
					next_out_adj = wd[7:4];
					next_in_adj  = wd[3:0];
				end
				`CLOC_IDX_SRC_SEL: begin
					next_sel2 = wd[6:5];
					if (!lock_main) begin
						next_sel3 = wd[4:3];
					end
					if (!lock_sel5) begin
						next_sel5 = wd[0];
					end
				end
				`CLOC_IDX_DIV_CTRL: begin
					next_b_div    = wd[7];
					next_c_div    = wd[6];
					next_mclk_div = wd[4:3];
					next_div3     = wd[2];
					if (!lock_main) begin
						next_div2 = wd[1];
						next_div5 = wd[0];
					end
				end
				`CLOC_IDX_OUT_EN: begin
					// reserved bits are stored as written; software keeps them set
					next_oe = wd[4:0];
				end
				`CLOC_IDX_SOFT_RST: begin
					next_init_cnt = 2'h1;
				end
				default: begin
				end
			endcase
		end
		// defaults that depend on the straps load once they have settled
		if (init_cnt == 2'h1) begin
			next_out_adj  = `CLOC_RST_LOAD_ADJ;
			next_in_adj   = `CLOC_RST_LOAD_ADJ;
			next_sel2     = `CLOC_RST_SEL2;
			next_sel3     = ovd ? `CLOC_RST_SEL3_FREE : `CLOC_RST_SEL3_LOCK;
			next_sel5     = (ovd | strap) ? `CLOC_SEL5_OSC : `CLOC_SEL5_FLL;
			next_b_div    = `CLOC_RST_B_DIV;
			next_c_div    = `CLOC_RST_C_DIV;
			next_mclk_div = `CLOC_RST_MCLK_DIV;
			next_div3     = `CLOC_RST_DIV3;
			next_div2     = ovd ? `CLOC_FREE_DIV : `CLOC_FORCE_DIV;
			next_div5     = ovd ? `CLOC_FREE_DIV : `CLOC_FORCE_DIV;
			next_oe       = `CLOC_RST_OE;
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			trim     <= 5'h00;
			unlocked <= 1'b0;
			init_cnt <= `CLOC_INIT_CYCLES;
			out_adj  <= `CLOC_RST_LOAD_ADJ;
			in_adj   <= `CLOC_RST_LOAD_ADJ;
			sel2     <= `CLOC_RST_SEL2;
			sel3     <= `CLOC_RST_SEL3_LOCK;
			sel5     <= `CLOC_SEL5_FLL;
			b_div    <= `CLOC_RST_B_DIV;
			c_div    <= `CLOC_RST_C_DIV;
			mclk_div <= `CLOC_RST_MCLK_DIV;
			div3     <= `CLOC_RST_DIV3;
			div2     <= `CLOC_FORCE_DIV;
			div5     <= `CLOC_FORCE_DIV;
			oe       <= `CLOC_RST_OE;
		end else begin
			trim     <= next_trim;
			unlocked <= next_unlocked;
			init_cnt <= next_init_cnt;
			out_adj  <= next_out_adj;
			in_adj   <= next_in_adj;
			sel2     <= next_sel2;
			sel3     <= next_sel3;
			sel5     <= next_sel5;
			b_div    <= next_b_div;
			c_div    <= next_c_div;
			mclk_div <= next_mclk_div;
			div3     <= next_div3;
			div2     <= next_div2;
			div5     <= next_div5;
			oe       <= next_oe;
		end
	end

	// ------------------------------------------------------------
	// read path and bus answer
	// ------------------------------------------------------------
	// answer is prepared in the setup cycle so every bus output is a flop
	logic [15:0] rd;
	logic        next_pready;
	logic [31:0] next_prdata;
	logic        next_pslverr;

	always_comb begin
		rd = 16'h0000;
		case (idx)
			`CLOC_IDX_TRIM:     rd = unlocked ? {11'h000, trim} : 16'h0000;
			`CLOC_IDX_LOAD_ADJ: rd = {8'h00, out_adj, in_adj};
			`CLOC_IDX_SRC_SEL:  rd = {9'h000, sel2, eff_sel3, 2'h0, eff_sel5};
			`CLOC_IDX_DIV_CTRL: rd = {8'h00, b_div, c_div, 1'b0, mclk_div, div3, eff_div2, eff_div5};
			`CLOC_IDX_OUT_EN:   rd = {11'h000, oe};
			`CLOC_IDX_KEY:      rd = {15'h0000, unlocked};
			default:            rd = 16'h0000;
		endcase
		next_pready  = setup;
		next_prdata  = (setup & ~pwrite & hit) ? {16'h0000, rd} : 32'h0000_0000;
		next_pslverr = setup & ~hit;
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			pready  <= 1'b0;
			prdata  <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else begin
			pready  <= next_pready;
			prdata  <= next_prdata;
			pslverr <= next_pslverr;
		end
	end

	// ------------------------------------------------------------
	// configuration outputs
	// ------------------------------------------------------------
	cloc_cfg_t next_cfg;

	always_comb begin
		next_cfg.second_output_source       = sel2;
		next_cfg.third_output_source        = eff_sel3;
		next_cfg.fifth_output_source        = eff_sel5;
		next_cfg.synth_b_output_divider     = b_div;
		next_cfg.synth_c_output_divider     = c_div;
		next_cfg.master_clock_divider       = mclk_div;
		next_cfg.third_output_divide        = div3;
		next_cfg.second_output_divide       = eff_div2;
		next_cfg.fifth_output_divide        = eff_div5;
		next_cfg.second_output_enable       = oe[3];
		next_cfg.third_output_enable        = oe[2];
		next_cfg.fifth_output_enable        = oe[0];
		next_cfg.output_crystal_load_adjust = out_adj;
		next_cfg.input_crystal_load_adjust  = in_adj;
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			cfg <= '0;
		end else begin
			cfg <= next_cfg;
		end
	end

endmodule

`default_nettype wire

/* File: dv/cloc_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
`include "cloc_defines.svh"
module cloc_assertions
	import cloc_pkg::*;
(
	// clock and reset
	input wire logic        clk,
	input wire logic        reset,
	// apb
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic        pready,
	input wire logic [31:0] prdata,
	input wire logic        pslverr,
	// straps and configuration
	input wire logic        clock_lock_override,
	input wire logic        osc_select_pin,
	input wire logic [4:0]  trim_code,
	input wire cloc_cfg_t   cfg
);
	// ----------------
	// helper state
	// ----------------
	logic [2:0] rel_cnt;
	logic [2:0] next_rel_cnt;
	logic       key_ok;
	logic       next_key_ok;
	logic       settled;
	logic       done_wr;
	assign done_wr = psel && penable && pready && pwrite;
	// straps pass a synchroniser, so lock checks wait until it has filled
	assign settled = rel_cnt == 3'h7;
	always_comb begin
		next_rel_cnt = settled ? rel_cnt : rel_cnt + 3'h1;
		next_key_ok = key_ok;
		if (done_wr && paddr == 12'h280)
			next_key_ok = pwdata[15:0] == `CLOC_KEY_VALUE;
	end
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			rel_cnt <= 3'h0;
			key_ok <= 1'b0;
		end else begin
			rel_cnt <= next_rel_cnt;
			key_ok <= next_key_ok;
		end
	end
	default clocking @(posedge clk);
	endclocking
	default disable iff (reset);
	sequence soft_wr;
		done_wr && paddr == 12'h1fc;
	endsequence
	sequence lock_low;
		(settled && !clock_lock_override)[*4];
	endsequence
	pready_once_a: assert property (psel && !penable |=> pready ##1 !pready)
		else $error("pready is not a single pulse after setup");
	sel3_lock_a: assert property (lock_low |-> cfg.third_output_source == 2'h2)
		else $error("third source not forced to loop");
	div2_lock_a: assert property (lock_low |-> cfg.second_output_divide)
		else $error("second divide not forced");
	div5_lock_a: assert property (lock_low |-> cfg.fifth_output_divide)
		else $error("fifth divide not forced");
	sel5_lock_a: assert property ((settled && !clock_lock_override && !osc_select_pin)[*4]
		|-> cfg.fifth_output_source) else $error("fifth source not forced");
	soft_defaults_a: assert property (soft_wr |-> ##3 (cfg.master_clock_divider == 2'h1
		&& cfg.synth_c_output_divider && !cfg.synth_b_output_divider && cfg.second_output_enable
		&& cfg.output_crystal_load_adjust == 4'h0)) else $error("soft reset left a field changed");
	trim_read_a: assert property (pready && !pwrite && paddr == 12'h1d0
		|-> prdata == (key_ok ? {27'h0, trim_code} : 32'h0)) else $error("trim read-back wrong");
	reset_reg_a: assert property (pready && !pwrite && paddr == 12'h1fc
		|-> prdata == 32'h0 && !pslverr) else $error("soft reset register not reading zero");
endmodule
bind cloc_top cloc_assertions u_cloc_assertions (
	.clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
	.clock_lock_override(clock_lock_override), .osc_select_pin(osc_select_pin),
	.trim_code(trim_code), .cfg(cfg)
);
`default_nettype wire

/* File: dv/cloc_top_tb.sv */
`timescale 1ns/1ps
`default_nettype none
`include "cloc_defines.svh"
module cloc_top_tb
	import cloc_pkg::*;
;
	logic        clk = 1'b0;
	logic        reset = 1'b1;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [11:0] paddr = 12'h0;
	logic [31:0] pwdata = 32'h0;
	logic        ovd = 1'b0;
	logic        strap = 1'b0;
	logic [4:0]  trim_code = 5'h15;
	logic        pready;
	logic [31:0] prdata;
	logic        pslverr;
	logic        last_err;
	cloc_cfg_t   cfg;
	int          failures = 0;
	int          total_checks = 0;
	always #20 clk = ~clk;
	cloc_top u_cloc_top (
		.clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
		.clock_lock_override(ovd), .osc_select_pin(strap), .trim_code(trim_code), .cfg(cfg)
	);
	// ----------------
	// bus tasks
	// ----------------
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			failures++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		// no local limit: only the watchdog ends a stalled transfer
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		r = prdata;
		last_err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] r;
		apb(1'b1, a, d, r);
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] exp);
		logic [31:0] r;
		apb(1'b0, a, 32'h0, r);
		chk(r, exp);
	endtask
	// straps are sampled after reset, so each strap setting gets its own reset
	task automatic do_reset(input logic o, input logic s);
		@(posedge clk);
		reset <= 1'b1;
		ovd <= o;
		strap <= s;
		repeat (6) @(posedge clk);
		reset <= 1'b0;
		repeat (4) @(posedge clk);
	endtask
	task automatic t_locked;
		do_reset(1'b0, 1'b0);
		rd(12'h1f0, 32'h11);
		rd(12'h1f4, 32'h4b);
		rd(12'h1f8, 32'h1f);
		rd(12'h1dc, 32'h0);
		wr(12'h1f0, 32'h40);
		wr(12'h1f4, 32'h80);
		rd(12'h1f0, 32'h51);
		rd(12'h1f4, 32'h83);
		$display("test locked done");
	endtask
	task automatic t_strap;
		do_reset(1'b0, 1'b1);
		rd(12'h1f0, 32'h10);
		wr(12'h1f0, 32'h01);
		rd(12'h1f0, 32'h11);
		$display("test strap done");
	endtask
	task automatic t_free;
		do_reset(1'b1, 1'b0);
		rd(12'h1f0, 32'h0);
		rd(12'h1f4, 32'h48);
		wr(12'h1f0, 32'h79);
		rd(12'h1f0, 32'h79);
		wr(12'h1f4, 32'hdf);
		rd(12'h1f4, 32'hdf);
		wr(12'h1dc, 32'h8f);
		rd(12'h1dc, 32'h8f);
		wr(12'h1f8, 32'h12);
		rd(12'h1f8, 32'h12);
		chk({31'h0, cfg.second_output_enable}, 32'h0);
		chk({9'h000, cfg}, 32'h007f_f88f);
		wr(12'h1fc, 32'h0);
		rd(12'h1f0, 32'h0);
		rd(12'h1f4, 32'h48);
		rd(12'h1f8, 32'h1f);
		rd(12'h1fc, 32'h0);
		$display("test free done");
	endtask
	task automatic t_trim;
		rd(12'h1d0, 32'h0);
		wr(12'h280, {16'h0, `CLOC_KEY_VALUE});
		rd(12'h1d0, 32'h15);
		wr(12'h1d0, 32'h0);
		rd(12'h1d0, 32'h15);
		trim_code <= 5'h0a;
		rd(12'h1d0, 32'h0a);
		wr(12'h280, 32'h0);
		rd(12'h1d0, 32'h0);
		wr(12'h300, 32'h1);
		chk({31'h0, last_err}, 32'h1);
		$display("test trim done");
	endtask
	task automatic report_and_stop;
		$display("checks=%0d failures=%0d", total_checks, failures);
		if (failures == 0 && total_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	initial begin
		t_locked();
		t_strap();
		t_free();
		t_trim();
		report_and_stop();
	end
	initial begin
		#120000;
		failures++;
		report_and_stop();
	end
endmodule
`default_nettype wire
